// ==== src/tsp_pkg.sv ====
// constants shared by both ends of the serial temperature sensor link
package tsp_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ        = 100_000_000;

  // frame layout
  localparam int         PHASE_BITS = 16;
  localparam logic [4:0] TX_LAST    = 5'h0F;
  localparam logic [4:0] RX_LAST    = 5'h1F;
  localparam logic [3:0] RX_NEED    = 4'h8;
  localparam logic [6:0] LEN_READ   = 7'h10;
  localparam logic [6:0] LEN_RDWR   = 7'h20;
  localparam logic [6:0] LEN_IDSEQ  = 7'h40;

  // mode codes
  localparam logic [7:0] MODE_SHUTDOWN = 8'hFF;
  localparam logic [7:0] MODE_CONVERT  = 8'h00;

  // transmitted word layout
  localparam int         TEMP_W   = 14;
  localparam logic [1:0] TEMP_PAD = 2'h3;
  // identification word: value is arbitrary, low two bits are ones
  localparam logic [15:0] ID_WORD_DEF = 16'h5A6B;

  // host operations
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_RDWR  = 2'h1;
  localparam logic [1:0] OP_IDSEQ = 2'h2;

  // link timing
  localparam int SCK_PERIOD_NS = 160;
  localparam int SETUP_NS      = 100;
  localparam int HOLD_NS       = 50;
  localparam int GAP_NS        = 160;
  localparam int SCK_HALF_CYC  =
    (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC  = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC   = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W     = 5;

  // conversion time
  localparam int CONV_TIME_MS = 228;
  localparam int CONV_CYCLES  = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int CONV_CNT_W   = 25;

endpackage : tsp_pkg

// ==== src/tsp_if.sv ====
// three-wire link between host and sensor, shared data line resolved here
`timescale 1ns/1ps
interface tsp_if;
  logic cs_n;
  logic sclk;
  logic host_sdo;
  logic host_oe;
  logic dev_sdo;
  logic dev_oe;
  logic sio;

  // released line floats high through a pull-up
  assign sio = dev_oe ? dev_sdo : (host_oe ? host_sdo : 1'h1);

  modport dev
  (
    input  cs_n,
    input  sclk,
    input  sio,
    output dev_sdo,
    output dev_oe
  );

  modport host
  (
    output cs_n,
    output sclk,
    output host_sdo,
    output host_oe,
    input  sio
  );
endinterface : tsp_if

// ==== src/tsp_dev.sv ====
// sensor end: serial slave, mode control and conversion timing
`timescale 1ns/1ps

// Notes on behaviour
// - drive on falling clock, sample on rising
// - chip select high one clock between frames
// - read frame is 16 clocks, one word
// - 32 clocks: 16 transmit then 16 receive
// - data line released while chip select high
// - host never selects on a rising clock
// - first bit driven at select, rest on falling
// - early deselect stops shifting, releases line
// - running conversion finishes; result applied after deselect
// - read gives last result, then conversion restarts
// - receive phase shifts line into eight bits
// - only last eight received bits are decoded
// - all ones shutdown, all zeros converting
// - host sends only the two mode codes; the bench also sends 5A to check o_test_code
// - powers up converting, first word invalid
// - host waits conversion time after resuming
// - temperature is 14-bit two's complement
// - upper 14 bits value, low bits ones
// - most significant bit sent first
// - link fully works during shutdown
// - shutdown reads return the identification word
// - identity read is four steps, one frame
module tsp_dev #(
  parameter int          CONV_CYCLES = tsp_pkg::CONV_CYCLES,
  parameter logic [15:0] ID_WORD     = tsp_pkg::ID_WORD_DEF
) (
  // clock and reset
  input  logic                        i_core_clk,
  input  logic                        i_reset_n,
  // link to host
  tsp_if.dev                          link,
  // converter side
  input  logic [tsp_pkg::TEMP_W-1:0]  i_temp_code,
  // status
  output logic                        o_shutdown,
  output logic                        o_conv_busy,
  output logic                        o_temp_valid,
  output logic                        o_test_code
);

  // pin synchronisers; stage 0 is read only by stage 1
  logic [2:0] cs_sync_q;
  logic [2:0] sck_sync_q;
  logic [1:0] sio_sync_q;

  // frame state
  logic [4:0] bit_cnt_q;
  logic       wait_q;
  logic [15:0] tx_q;
  logic [7:0] rx_q;
  logic [3:0] rx_n_q;

  // mode and conversion
  logic                         shutdown_q;
  logic                         test_q;
  logic                         busy_q;
  logic [tsp_pkg::CONV_CNT_W-1:0] conv_cnt_q;
  logic                         pend_q;
  logic [tsp_pkg::TEMP_W-1:0]   pend_val_q;
  logic [tsp_pkg::TEMP_W-1:0]   result_q;
  logic                         valid_q;

  // combinational
  logic       cs_low;
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       tx_phase;
  logic       rx_shift;
  logic [7:0] rx_next;
  logic [3:0] rx_n_next;
  logic       wrap;
  logic       decode_ok;
  logic       shutdown_d;
  logic       bad_code;
  logic [15:0] word_sel;
  logic       conv_done;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      cs_sync_q  <= 3'h7;
      sck_sync_q <= 3'h0;
      sio_sync_q <= 2'h3;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[1:0], link.cs_n};
      sck_sync_q <= {sck_sync_q[1:0], link.sclk};
      sio_sync_q <= {sio_sync_q[0], link.sio};
    end
  end

  assign cs_low   = ~cs_sync_q[1];
  assign cs_fall  = ~cs_sync_q[1] & cs_sync_q[2];
  assign cs_rise  = cs_sync_q[1] & ~cs_sync_q[2];
  // select only ever falls with the clock low, so edges are unambiguous
  assign sck_rise = cs_low & sck_sync_q[1] & ~sck_sync_q[2];
  assign sck_fall = cs_low & ~sck_sync_q[1] & sck_sync_q[2];
  assign tx_phase = ~bit_cnt_q[4];
  assign rx_shift = sck_rise & ~tx_phase;
  assign rx_next  = rx_shift ? {rx_q[6:0], sio_sync_q[1]} : rx_q;
  assign rx_n_next = (rx_shift && rx_n_q != tsp_pkg::RX_NEED) ?
                     rx_n_q + 4'h1 : rx_n_q;
  // a 32-clock boundary under select acts like a deselect for decoding,
  // so the four-step identity read works inside one frame
  assign wrap      = sck_rise && bit_cnt_q == tsp_pkg::RX_LAST;
  assign decode_ok = (wrap | cs_rise) && rx_n_next == tsp_pkg::RX_NEED;
  assign bad_code  = decode_ok && rx_next != tsp_pkg::MODE_SHUTDOWN &&
                     rx_next != tsp_pkg::MODE_CONVERT;

  always_comb
  begin
    shutdown_d = shutdown_q;
    if (decode_ok && rx_next == tsp_pkg::MODE_SHUTDOWN)
      shutdown_d = 1'h1;
    else if (decode_ok && rx_next == tsp_pkg::MODE_CONVERT)
      shutdown_d = 1'h0;
  end

  assign word_sel = shutdown_d ? ID_WORD : {result_q, tsp_pkg::TEMP_PAD};

  // clock count within the frame, wraps every 32
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n || !cs_low)
      bit_cnt_q <= 5'h00;
    else if (sck_rise)
      bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  // after a wrap, wait for the falling edge so the host has let go first
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n || !cs_low)
      wait_q <= 1'h0;
    else if (wrap)
      wait_q <= 1'h1;
    else if (sck_fall)
      wait_q <= 1'h0;
  end

  // output shifter, MSB first, fills with ones
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      tx_q <= 16'hFFFF;
    else if (cs_fall || wrap)
      tx_q <= word_sel;
    else if (sck_fall && tx_phase && bit_cnt_q != 5'h00 && !wait_q)
      tx_q <= {tx_q[14:0], 1'h1};
  end

  // input shifter; only the last eight bits survive
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      rx_q   <= 8'h00;
      rx_n_q <= 4'h0;
    end
    else if (cs_fall || wrap || cs_rise)
    begin
      rx_q   <= rx_next;
      rx_n_q <= 4'h0;
    end
    else
    begin
      rx_q   <= rx_next;
      rx_n_q <= rx_n_next;
    end
  end

  // mode; frames are served the same way in either mode
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      shutdown_q <= 1'h0;
      test_q     <= 1'h0;
    end
    else
    begin
      shutdown_q <= shutdown_d;
      test_q     <= bad_code;
    end
  end

  // drive under select in the transmit phase, once the word is loaded,
  // so the stale shifter never reaches the line
  assign link.dev_oe  = cs_low & ~cs_fall & tx_phase & ~wait_q;
  assign link.dev_sdo = tx_q[15];

  assign conv_done = busy_q &&
    conv_cnt_q == tsp_pkg::CONV_CNT_W'(CONV_CYCLES - 1);

  // conversion timer; a read frame never aborts it, only delays the restart; shutdown clears it
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      busy_q     <= 1'h1;
      conv_cnt_q <= '0;
    end
    else if (shutdown_q)
    begin
      busy_q     <= 1'h0;
      conv_cnt_q <= '0;
    end
    else if (conv_done)
    begin
      busy_q     <= ~cs_low;
      conv_cnt_q <= '0;
    end
    else if (busy_q)
      conv_cnt_q <= conv_cnt_q + tsp_pkg::CONV_CNT_W'(1);
    else if (!cs_low)
      busy_q <= 1'h1;
  end

  // result holding; a result finished under select waits for deselect
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      pend_q     <= 1'h0;
      pend_val_q <= '0;
      result_q   <= '0;
      valid_q    <= 1'h0;
    end
    else if (conv_done && cs_low)
    begin
      pend_q     <= 1'h1;
      pend_val_q <= i_temp_code;
    end
    else if (conv_done)
    begin
      pend_q   <= 1'h0;
      result_q <= i_temp_code;
      valid_q  <= 1'h1;
    end
    else if (pend_q && !cs_low)
    begin
      pend_q   <= 1'h0;
      result_q <= pend_val_q;
      valid_q  <= 1'h1;
    end
  end

  assign o_shutdown   = shutdown_q;
  assign o_conv_busy  = busy_q;
  assign o_temp_valid = valid_q;
  assign o_test_code  = test_q;

endmodule : tsp_dev

// ==== src/tsp_host.sv ====
// host end: serial master making select, clock and write data
`timescale 1ns/1ps
module tsp_host (
  // clock and reset
  input  logic        i_core_clk,
  input  logic        i_reset_n,
  // link to sensor
  tsp_if.host         link,
  // command
  input  logic        i_start,
  input  logic [1:0]  i_op,
  input  logic [4:0]  i_rd_bits,
  input  logic [7:0]  i_code,
  // answer
  output logic        o_busy,
  output logic [15:0] o_rd_data,
  output logic        o_done
);

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_HIGH, H_LOW, H_HOLD, H_GAP
  } tsp_host_state_e;

  tsp_host_state_e st_q;
  logic [tsp_pkg::TMR_W-1:0] tmr_q;
  logic [6:0]  clk_n_q;
  logic [6:0]  len_q;
  logic [1:0]  op_q;
  logic [7:0]  code_q;
  logic [1:0]  sio_sync_q;
  logic [15:0] shift_q;
  logic        cs_n_q;
  logic        sck_q;
  logic        sdo_q;
  logic        oe_q;
  logic [15:0] rd_q;
  logic        done_q;

  logic       tmr_done;
  logic       go_start;
  logic       go_rise;
  logic       go_fall;
  logic       go_end;
  logic [6:0] len_d;
  logic [7:0] wr_byte;

  assign tmr_done = tmr_q == '0;
  assign go_start = st_q == H_IDLE && i_start;
  assign go_rise  = tmr_done && (st_q == H_SETUP || st_q == H_LOW);
  assign go_fall  = tmr_done && st_q == H_HIGH;
  assign go_end   = tmr_done && st_q == H_HOLD;

  always_comb
  begin
    len_d = tsp_pkg::LEN_READ;
    if (i_op == tsp_pkg::OP_RDWR)
      len_d = tsp_pkg::LEN_RDWR;
    else if (i_op == tsp_pkg::OP_IDSEQ)
      len_d = tsp_pkg::LEN_IDSEQ;
    else if (i_rd_bits != 5'h00)
      len_d = {2'h0, i_rd_bits};
  end

  // shutdown code in the second phase of the identity sequence
  assign wr_byte = (op_q == tsp_pkg::OP_IDSEQ && clk_n_q[5:4] == 2'h1) ?
                   tsp_pkg::MODE_SHUTDOWN : code_q;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      sio_sync_q <= 2'h3;
    else
      sio_sync_q <= {sio_sync_q[0], link.sio};
  end

  // sequencer and timer
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      st_q    <= H_IDLE;
      tmr_q   <= '0;
      clk_n_q <= 7'h00;
      len_q   <= tsp_pkg::LEN_READ;
      op_q    <= tsp_pkg::OP_READ;
      code_q  <= tsp_pkg::MODE_CONVERT;
    end
    else
    begin
      if (!tmr_done)
        tmr_q <= tmr_q - tsp_pkg::TMR_W'(1);
      unique case (st_q)
        H_IDLE:
          if (go_start)
          begin
            st_q    <= H_SETUP;
            tmr_q   <= tsp_pkg::TMR_W'(tsp_pkg::SETUP_CYC - 1);
            clk_n_q <= 7'h00;
            len_q   <= len_d;
            op_q    <= i_op;
            code_q  <= i_code;
          end
        H_SETUP, H_LOW:
          if (go_rise)
          begin
            st_q    <= H_HIGH;
            tmr_q   <= tsp_pkg::TMR_W'(tsp_pkg::SCK_HALF_CYC - 1);
            clk_n_q <= clk_n_q + 7'h01;
          end
        H_HIGH:
          if (go_fall)
          begin
            st_q  <= (clk_n_q == len_q) ? H_HOLD : H_LOW;
            tmr_q <= (clk_n_q == len_q) ?
                     tsp_pkg::TMR_W'(tsp_pkg::HOLD_CYC - 1) :
                     tsp_pkg::TMR_W'(tsp_pkg::SCK_HALF_CYC - 1);
          end
        H_HOLD:
          if (go_end)
          begin
            st_q  <= H_GAP;
            tmr_q <= tsp_pkg::TMR_W'(tsp_pkg::GAP_CYC - 1);
          end
        H_GAP:
          if (tmr_done)
            st_q <= H_IDLE;
      endcase
    end
  end

  // link pins; write data changes on falling edges only
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      cs_n_q <= 1'h1;
      sck_q  <= 1'h0;
      sdo_q  <= 1'h1;
      oe_q   <= 1'h0;
    end
    else if (go_start)
      cs_n_q <= 1'h0;
    else if (go_rise)
      sck_q <= 1'h1;
    else if (go_fall)
    begin
      sck_q <= 1'h0;
      oe_q  <= clk_n_q[4] && clk_n_q != len_q;
      sdo_q <= wr_byte[3'h7 - clk_n_q[2:0]];
    end
    else if (go_end)
    begin
      cs_n_q <= 1'h1;
      oe_q   <= 1'h0;
    end
  end

  // read data, sampled at the rising edge of read-phase clocks
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      shift_q <= 16'h0000;
      rd_q    <= 16'h0000;
      done_q  <= 1'h0;
    end
    else
    begin
      done_q <= go_end;
      if (go_start)
        shift_q <= 16'h0000;
      else if (go_rise && !clk_n_q[4])
        shift_q <= {shift_q[14:0], sio_sync_q[1]};
      if (go_end)
        rd_q <= shift_q;
    end
  end

  assign link.cs_n     = cs_n_q;
  assign link.sclk     = sck_q;
  assign link.host_sdo = sdo_q;
  assign link.host_oe  = oe_q;
  assign o_busy        = st_q != H_IDLE;
  assign o_rd_data     = rd_q;
  assign o_done        = done_q;

endmodule : tsp_host

// ==== dv/tsp_checker.sv ====
// assertions on the wires of the sensor link
`timescale 1ns/1ps
module tsp_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic dev_sdo
);
  logic       sclk_q;
  logic [6:0] rise_q;
  logic [4:0] hi_q;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  always_ff @(posedge i_core_clk)
  begin
    sclk_q <= sclk;
  end

  // rising clocks counted since select
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n || cs_n)
      rise_q <= 7'h00;
    else if (sclk && !sclk_q)
      rise_q <= rise_q + 7'h01;
  end

  // reset counts as a long idle gap
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      hi_q <= 5'h1F;
    else if (!cs_n)
      hi_q <= 5'h00;
    else if (hi_q != 5'h1F)
      hi_q <= hi_q + 5'h01;
  end

  idle_release_a : assert property (cs_n [*5] |-> !dev_oe)
    else $error("sensor drives line while deselected");
  no_contention_a : assert property (!(dev_oe && host_oe))
    else $error("both ends drive the data line");
  first_bit_a : assert property ($fell(cs_n) |-> ##[1:5] dev_oe)
    else $error("first bit not driven after select");
  bit_stable_a : assert property (dev_oe && $past(dev_oe) && sclk
    && $past(sclk) |-> $stable(dev_sdo))
    else $error("sensor data changed while clock high");
  rx_released_a : assert property (!cs_n && ((rise_q[4:0] == 5'h10
    && !sclk) || rise_q[4:0] > 5'h10) |-> !dev_oe)
    else $error("sensor drives line in receive phase");
  cs_gap_a : assert property ($fell(cs_n) |-> hi_q >= 5'h10)
    else $error("select gap too short");
  select_setup_a : assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("clock rose too soon after select");
  idle_clock_a : assert property (cs_n |-> !sclk)
    else $error("clock high while deselected");
  half_period_a : assert property ($rose(sclk) |-> sclk [*8])
    else $error("clock high phase too short");
endmodule : tsp_checker

// ==== dv/tsp_test.sv ====
// self-checking bench: host and sensor ends joined by the link
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s exp %h got %h", nm, ex, got); \
    end \
  end
module tsp_test;
  localparam int          CONV = 200;
  // arbitrary identification word, low two bits ones
  localparam logic [15:0] ID   = 16'hC5A7;
  logic        i_core_clk;
  logic        i_reset_n;
  logic        i_start;
  logic [1:0]  i_op;
  logic [4:0]  i_rd_bits;
  logic [7:0]  i_code;
  logic [13:0] i_temp_code;
  logic        o_busy;
  logic [15:0] o_rd_data;
  logic        o_done;
  logic        o_shutdown;
  logic        o_conv_busy;
  logic        o_temp_valid;
  logic        o_test_code;
  logic        saw_test;
  logic [15:0] tword;
  logic [15:0] expd;
  logic [15:0] msk;
  logic [15:0] exp_q[$];
  int          n_mismatch;
  int          num_checks;
  int          cycles;
  int          seed;
  int          shut;

  tsp_if lnk ();
  tsp_dev #(.CONV_CYCLES(CONV), .ID_WORD(ID)) tsp_dev_i (
    .i_core_clk, .i_reset_n, .link(lnk), .i_temp_code,
    .o_shutdown, .o_conv_busy, .o_temp_valid, .o_test_code);
  tsp_host tsp_host_i (
    .i_core_clk, .i_reset_n, .link(lnk), .i_start, .i_op,
    .i_rd_bits, .i_code, .o_busy, .o_rd_data, .o_done);
  tsp_checker tsp_checker_i (
    .i_core_clk, .i_reset_n, .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .host_oe(lnk.host_oe), .dev_oe(lnk.dev_oe), .dev_sdo(lnk.dev_sdo));

  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // end the run as failed after 30000 cycles on hangs rather than wait forever
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (o_test_code === 1'b1)
      saw_test = 1'b1;
    if (cycles == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : idle

  // one host command; model predicts the read word and mode
  task automatic run(input logic [1:0] op, input logic [4:0] n,
                     input logic [7:0] code);
    logic [15:0] w;
    int          k;
    w = shut ? ID : tword;
    if (op == tsp_pkg::OP_IDSEQ)
      w = ID;
    msk = (n == 5'h00) ? 16'hFFFF : ~(16'hFFFF << n);
    exp_q.push_back((n == 5'h00) ? w : w >> (16 - n));
    if (op != tsp_pkg::OP_READ && code == tsp_pkg::MODE_SHUTDOWN)
      shut = 1;
    else if (op != tsp_pkg::OP_READ && code == tsp_pkg::MODE_CONVERT)
      shut = 0;
    k = 0;
    while (o_busy !== 1'b0 && k < 100)
    begin
      idle(1);
      k++;
    end
    i_op = op;
    i_rd_bits = n;
    i_code = code;
    i_start = 1'b1;
    idle(1);
    i_start = 1'b0;
    k = 0;
    while (o_done !== 1'b1 && k < 2000)
    begin
      idle(1);
      k++;
    end
    if (k >= 2000)
      n_mismatch++;
    expd = exp_q.pop_front();
    expd = expd & msk;
    msk = o_rd_data & msk;
    idle(10);
  endtask : run

  initial
  begin
    seed = 32'h0279;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    shut = 0;
    saw_test = 1'b0;
    tword = 16'h0003;
    i_reset_n = 1'b0;
    i_start = 1'b0;
    i_op = 2'h0;
    i_rd_bits = 5'h00;
    i_code = 8'h00;
    i_temp_code = $random(seed);
    repeat (3) @(posedge i_core_clk);
    #1;
    i_reset_n = 1'b1;
    `CHK("temp_valid", 1'b0, o_temp_valid)
    `CHK("conv_busy", 1'b1, o_conv_busy)
    run(tsp_pkg::OP_READ, 5'h00, 8'h00);
    `CHK("rd_data", expd, msk)
    tword = {i_temp_code, 2'h3};
    idle(20);
    `CHK("temp_valid", 1'b1, o_temp_valid)
    run(tsp_pkg::OP_READ, 5'h00, 8'h00);
    `CHK("rd_data", expd, msk)
    for (int i = 0; i < 6; i++)
    begin
      i_temp_code = (i == 0) ? 14'h2000 : $random(seed);
      tword = {i_temp_code, 2'h3};
      idle(2 * CONV + 40);
      run(tsp_pkg::OP_READ, 5'(i * 3), 8'h00);
      `CHK("rd_data", expd, msk)
    end
    run(tsp_pkg::OP_RDWR, 5'h00, tsp_pkg::MODE_SHUTDOWN);
    `CHK("rd_data", expd, msk)
    `CHK("shutdown", 1'b1, o_shutdown)
    run(tsp_pkg::OP_READ, 5'h00, 8'h00);
    `CHK("rd_data", expd, msk)
    saw_test = 1'b0;
    run(tsp_pkg::OP_RDWR, 5'h00, 8'h5A);
    `CHK("rd_data", expd, msk)
    `CHK("test_code", 1'b1, saw_test)
    `CHK("shutdown", 1'b1, o_shutdown)
    run(tsp_pkg::OP_RDWR, 5'h00, tsp_pkg::MODE_CONVERT);
    `CHK("rd_data", expd, msk)
    `CHK("shutdown", 1'b0, o_shutdown)
    i_temp_code = $random(seed);
    tword = {i_temp_code, 2'h3};
    idle(2 * CONV + 40);
    run(tsp_pkg::OP_READ, 5'h00, 8'h00);
    `CHK("rd_data", expd, msk)
    run(tsp_pkg::OP_IDSEQ, 5'h00, tsp_pkg::MODE_CONVERT);
    `CHK("rd_data", expd, msk)
    `CHK("shutdown", 1'b0, o_shutdown)
    run(tsp_pkg::OP_RDWR, 5'h00, tsp_pkg::MODE_SHUTDOWN);
    `CHK("rd_data", expd, msk)
    `CHK("conv_busy", 1'b0, o_conv_busy)
    // mid-run reset: power-up state must return from shutdown
    i_reset_n = 1'b0;
    idle(3);
    i_reset_n = 1'b1;
    shut = 0;
    tword = 16'h0003;
    `CHK("shutdown", 1'b0, o_shutdown)
    `CHK("temp_valid", 1'b0, o_temp_valid)
    `CHK("conv_busy", 1'b1, o_conv_busy)
    run(tsp_pkg::OP_READ, 5'h00, 8'h00);
    `CHK("rd_data", expd, msk)
    test_done();
  end
endmodule : tsp_test
